// [src/extension_enable_fuse_exec.sv]
`timescale 1ns/1ps
module extension_enable_fuse_exec #(
   parameter int AW = extension_enable_fuse_pkg::DATA_AW,
   parameter int PW = extension_enable_fuse_pkg::PC_W
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_fuse,
   input wire logic i_valid,
   input wire logic [15:0] i_word,
   input wire logic [PW-1:0] i_pc,
   input wire logic [PW-1:0] i_tos,
   input wire logic [7:0] i_working,
   input wire logic [7:0] i_latch_high,
   input wire logic [7:0] i_latch_upper,
   input wire logic [7:0] i_rd_data,
   output logic [AW-1:0] o_ptr0,
   output logic [AW-1:0] o_ptr1,
   output logic [AW-1:0] o_ptr2,
   output logic o_pc_load,
   output logic [PW-1:0] o_pc_value,
   output logic o_push_ret,
   output logic [PW-1:0] o_push_value,
   output logic o_flush,
   output logic o_busy,
   output logic o_rd_en,
   output logic [AW-1:0] o_rd_addr,
   output logic o_wr_en,
   output logic [AW-1:0] o_wr_addr,
   output logic [7:0] o_wr_data
);
   // Extended instructions never touch working, status or bank select,
   // so this block has no output toward them; i_working is only read.
   logic fuse_s1_q, fuse_q;
   logic dec_add, dec_sub, dec_push, dec_move, dec_call_working;
   logic busy_q, busy_d;
   extension_enable_fuse_pkg::exec_state_t state_q, state_d;
   logic [AW-1:0] ptr_q [3];
   logic [AW-1:0] ptr_d [3];
   logic pc_load_q, pc_load_d, push_q, push_d, flush_q, flush_d;
   logic [PW-1:0] pc_val_q, pc_val_d, push_val_q, push_val_d;
   logic rd_en_q, rd_en_d, wr_en_q, wr_en_d, to_file_q, to_file_d;
   logic [AW-1:0] rd_addr_q, rd_addr_d, wr_addr_q, wr_addr_d;
   logic [7:0] wr_data_q, wr_data_d, src_q, src_d;
   logic [1:0] sel;
   logic [AW-1:0] lit6;

   default clocking @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);

   function automatic logic is_indirect(input logic [AW-1:0] a);
      return a >= extension_enable_fuse_pkg::IND_BASE && a <= extension_enable_fuse_pkg::IND_LAST;
   endfunction

   function automatic logic [AW-1:0] frame_rel(input logic [AW-1:0] f,
                                               input logic [6:0] off);
      return AW'(f + {{(AW-7){1'b0}}, off});
   endfunction

   extension_enable_fuse_decode u_decode (
      .i_word(i_word),
      .i_enable(fuse_q),
      .o_add(dec_add),
      .o_sub(dec_sub),
      .o_push(dec_push),
      .o_move(dec_move),
      .o_call_working(dec_call_working)
   );

   assign sel = i_word[7:6];
   assign lit6 = {{(AW-6){1'b0}}, i_word[5:0]};

   always_comb begin
      state_d = state_q;
      ptr_d = ptr_q;
      pc_load_d = 1'b0;
      pc_val_d = pc_val_q;
      push_d = 1'b0;
      push_val_d = push_val_q;
      flush_d = 1'b0;
      rd_en_d = 1'b0;
      rd_addr_d = rd_addr_q;
      wr_en_d = 1'b0;
      wr_addr_d = wr_addr_q;
      wr_data_d = wr_data_q;
      to_file_d = to_file_q;
      src_d = src_q;
      case (state_q)
         extension_enable_fuse_pkg::ST_EXEC: begin
            if (i_valid && dec_add) begin
               if (sel == extension_enable_fuse_pkg::SEL_RETURN) begin
                  ptr_d[extension_enable_fuse_pkg::SEL_FRAME] =
                     ptr_q[extension_enable_fuse_pkg::SEL_FRAME] + lit6;
                  pc_load_d = 1'b1;
                  pc_val_d = i_tos;
                  flush_d = 1'b1;
                  state_d = extension_enable_fuse_pkg::ST_IDLE;
               end else begin
                  ptr_d[sel] = ptr_q[sel] + lit6;
               end
            end else if (i_valid && dec_sub) begin
               if (sel == extension_enable_fuse_pkg::SEL_RETURN) begin
                  ptr_d[extension_enable_fuse_pkg::SEL_FRAME] =
                     ptr_q[extension_enable_fuse_pkg::SEL_FRAME] - lit6;
                  pc_load_d = 1'b1;
                  pc_val_d = i_tos;
                  flush_d = 1'b1;
                  state_d = extension_enable_fuse_pkg::ST_IDLE;
               end else begin
                  ptr_d[sel] = ptr_q[sel] - lit6;
               end
            end else if (i_valid && dec_push) begin
               wr_en_d = 1'b1;
               wr_addr_d = ptr_q[extension_enable_fuse_pkg::SEL_FRAME];
               wr_data_d = i_word[7:0];
               ptr_d[extension_enable_fuse_pkg::SEL_FRAME] =
                  ptr_q[extension_enable_fuse_pkg::SEL_FRAME] - extension_enable_fuse_pkg::PUSH_STEP;
            end else if (i_valid && dec_call_working) begin
               push_d = 1'b1;
               push_val_d = PW'(i_pc + extension_enable_fuse_pkg::PC_STEP);
               pc_load_d = 1'b1;
               pc_val_d = {i_latch_upper[PW-17:0], i_latch_high, i_working};
               flush_d = 1'b1;
               state_d = extension_enable_fuse_pkg::ST_IDLE;
            end else if (i_valid && dec_move) begin
               rd_addr_d = frame_rel(ptr_q[extension_enable_fuse_pkg::SEL_FRAME], i_word[6:0]);
               // Indirect sources are skipped to avoid their side effects.
               rd_en_d = ~is_indirect(rd_addr_d);
               to_file_d = ~i_word[7];
               state_d = extension_enable_fuse_pkg::ST_MOVE_RD;
            end
         end
         extension_enable_fuse_pkg::ST_IDLE: begin
            state_d = extension_enable_fuse_pkg::ST_EXEC;
         end
         extension_enable_fuse_pkg::ST_MOVE_RD: begin
            // Word two is fetched during this cycle; source data returns too.
            src_d = is_indirect(rd_addr_q) ? extension_enable_fuse_pkg::ZERO_BYTE
                                            : i_rd_data;
            if (i_valid && i_word[15:12] == extension_enable_fuse_pkg::WORD2_TAG) begin
               state_d = extension_enable_fuse_pkg::ST_MOVE_WR;
               if (to_file_q) begin
                  wr_addr_d = i_word[AW-1:0];
                  wr_en_d = 1'b1;
               end else begin
                  wr_addr_d = frame_rel(ptr_q[extension_enable_fuse_pkg::SEL_FRAME],
                                        i_word[6:0]);
                  wr_en_d = ~is_indirect(wr_addr_d);
               end
               wr_data_d = src_d;
            end
         end
         extension_enable_fuse_pkg::ST_MOVE_WR: begin
            state_d = extension_enable_fuse_pkg::ST_EXEC;
         end
         default: begin
            state_d = extension_enable_fuse_pkg::ST_EXEC;
         end
      endcase
      busy_d = state_d != extension_enable_fuse_pkg::ST_EXEC;
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fuse_s1_q <= 1'b0;
         fuse_q <= 1'b0;
         state_q <= extension_enable_fuse_pkg::ST_EXEC;
         for (int i = 0; i < 3; i++) begin
            ptr_q[i] <= '0;
         end
         pc_load_q <= 1'b0;
         pc_val_q <= '0;
         push_q <= 1'b0;
         push_val_q <= '0;
         flush_q <= 1'b0;
         rd_en_q <= 1'b0;
         rd_addr_q <= '0;
         wr_en_q <= 1'b0;
         wr_addr_q <= '0;
         wr_data_q <= '0;
         to_file_q <= 1'b0;
         src_q <= '0;
         busy_q <= 1'b0;
      end else begin
         fuse_s1_q <= i_fuse;
         fuse_q <= fuse_s1_q;
         state_q <= state_d;
         ptr_q <= ptr_d;
         pc_load_q <= pc_load_d;
         pc_val_q <= pc_val_d;
         push_q <= push_d;
         push_val_q <= push_val_d;
         flush_q <= flush_d;
         rd_en_q <= rd_en_d;
         rd_addr_q <= rd_addr_d;
         wr_en_q <= wr_en_d;
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
         to_file_q <= to_file_d;
         src_q <= src_d;
         busy_q <= busy_d;
      end
   end

   always_comb begin
      o_ptr0 = ptr_q[0];
      o_ptr1 = ptr_q[1];
      o_ptr2 = ptr_q[2];
      o_pc_load = pc_load_q;
      o_pc_value = pc_val_q;
      o_push_ret = push_q;
      o_push_value = push_val_q;
      o_flush = flush_q;
      o_busy = busy_q;
      o_rd_en = rd_en_q;
      o_rd_addr = rd_addr_q;
      o_wr_en = wr_en_q;
      o_wr_addr = wr_addr_q;
      o_wr_data = wr_data_q;
   end

   sequence s_ret_issue;
      state_q == extension_enable_fuse_pkg::ST_EXEC && i_valid && (dec_add || dec_sub)
         && sel == extension_enable_fuse_pkg::SEL_RETURN;
   endsequence

   a_ret_loads_pc: assert property (
      s_ret_issue |=> o_pc_load && o_flush && o_pc_value == $past(i_tos)
         ##1 !o_pc_load)
      else $error("return variant did not load counter");
   a_add_ptr: assert property (
      state_q == extension_enable_fuse_pkg::ST_EXEC && i_valid && dec_add && sel == 2'h0
      |=> o_ptr0 == $past(o_ptr0) + $past(lit6) && !o_busy)
      else $error("add to pointer wrong");
   a_sub_ptr: assert property (
      state_q == extension_enable_fuse_pkg::ST_EXEC && i_valid && dec_sub && sel == 2'h1
      |=> o_ptr1 == $past(o_ptr1) - $past(lit6))
      else $error("subtract from pointer wrong");
   a_sub_frame: assert property (
      state_q == extension_enable_fuse_pkg::ST_EXEC && i_valid && dec_sub
      && sel == extension_enable_fuse_pkg::SEL_RETURN
      |=> o_ptr2 == $past(o_ptr2) - $past(lit6) && o_busy)
      else $error("frame subtract return wrong");
   a_call_push: assert property (
      state_q == extension_enable_fuse_pkg::ST_EXEC && i_valid && dec_call_working
      |=> o_push_ret && o_push_value == $past(i_pc) + extension_enable_fuse_pkg::PC_STEP
         && o_pc_value[7:0] == $past(i_working))
      else $error("indirect call push wrong");
   a_call_idle: assert property (
      state_q == extension_enable_fuse_pkg::ST_EXEC && i_valid && dec_call_working
      |=> o_busy ##1 !o_busy && !o_wr_en)
      else $error("indirect call not two cycles");
   a_push_write: assert property (
      state_q == extension_enable_fuse_pkg::ST_EXEC && i_valid && dec_push
      |=> o_wr_en && o_wr_addr == $past(o_ptr2)
         && o_ptr2 == $past(o_ptr2) - extension_enable_fuse_pkg::PUSH_STEP)
      else $error("push literal wrong");
   a_fuse_gate: assert property (
      !fuse_q |=> !o_wr_en && !o_pc_load && !o_push_ret)
      else $error("extension acted while disabled");
   a_ind_dest: assert property (
      o_wr_en && state_q == extension_enable_fuse_pkg::ST_MOVE_WR && !to_file_q
      |-> !is_indirect(o_wr_addr))
      else $error("write into indirect register");
   a_move_len: assert property (
      state_q == extension_enable_fuse_pkg::ST_MOVE_RD && i_valid
         && i_word[15:12] == extension_enable_fuse_pkg::WORD2_TAG
      |=> state_q == extension_enable_fuse_pkg::ST_MOVE_WR ##1 state_q == extension_enable_fuse_pkg::ST_EXEC)
      else $error("move did not reach its write cycle");
endmodule

// [inc/extension_enable_fuse_pkg.sv]
// Function
// - Add 6-bit literal to selected index pointer in one cycle.
// - Select 11 on add: frame pointer plus literal, return, idle cycle.
// - Subtract 6-bit literal from selected index pointer in one cycle.
// - Select 11 on subtract: frame pointer minus literal, return, idle.
// - Indirect call pushes address plus 2, jumps to latches and working.
// - Indirect call second cycle is idle while the target is fetched.
// - Indirect call leaves working, status and bank select untouched.
// - File move reads at frame plus offset, writes to word-two address.
// - Indexed move uses frame plus offset for both addresses.
// - Computed move addresses cover the whole 4096-byte data space.
// - Source in an indirect register reads as zero.
// - Indexed destination in an indirect register suppresses the write; file destinations always write.
// - Push literal writes at frame pointer, then decrements it.
// - Extended instructions decode only while the enable fuse is set.
package extension_enable_fuse_pkg;
   localparam int DATA_AW = 12;
   localparam int PC_W = 21;
   localparam logic [7:0] OP_ADD_PTR = 8'hE8;
   localparam logic [7:0] OP_SUB_PTR = 8'hE9;
   localparam logic [7:0] OP_PUSH = 8'hFA;
   localparam logic [7:0] OP_MOVE = 8'hEB;
   localparam logic [15:0] OP_CALL_WORKING = 16'h0014;
   localparam logic [3:0] WORD2_TAG = 4'hF;
   localparam logic [1:0] SEL_FRAME = 2'h2;
   localparam logic [1:0] SEL_RETURN = 2'h3;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
   localparam logic [DATA_AW-1:0] PUSH_STEP = 12'h001;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // Indirect addressing registers sit in the top page of data space.
   localparam logic [DATA_AW-1:0] IND_BASE = 12'hFDB;
   localparam logic [DATA_AW-1:0] IND_LAST = 12'hFEF;
   typedef enum logic [2:0] {
      ST_EXEC, ST_IDLE, ST_MOVE_RD, ST_MOVE_WR
   } exec_state_t;
endpackage

// [src/extension_enable_fuse_decode.sv]
`timescale 1ns/1ps
module extension_enable_fuse_decode (
   input wire logic [15:0] i_word,
   input wire logic i_enable,
   output logic o_add,
   output logic o_sub,
   output logic o_push,
   output logic o_move,
   output logic o_call_working
);
   always_comb begin
      o_add = i_enable && i_word[15:8] == extension_enable_fuse_pkg::OP_ADD_PTR;
      o_sub = i_enable && i_word[15:8] == extension_enable_fuse_pkg::OP_SUB_PTR;
      o_push = i_enable && i_word[15:8] == extension_enable_fuse_pkg::OP_PUSH;
      o_move = i_enable && i_word[15:8] == extension_enable_fuse_pkg::OP_MOVE;
      o_call_working = i_enable && i_word == extension_enable_fuse_pkg::OP_CALL_WORKING;
   end
endmodule

// [tb/tb_extended_stack_instruction_exec.sv]
`timescale 1ns/1ps
module tb_extended_stack_instruction_exec;
   logic i_clock = 1'b0, i_rst_n = 1'b0, i_fuse = 1'b0, i_valid = 1'b0;
   logic [15:0] i_word = 16'h0000;
   logic [20:0] i_pc = 21'h000000, i_tos = 21'h000000;
   logic [7:0] i_working = 8'h00, i_latch_high = 8'h00;
   logic [7:0] i_latch_upper = 8'h00, i_rd_data = 8'h00;
   logic [11:0] o_ptr0, o_ptr1, o_ptr2, o_rd_addr, o_wr_addr;
   logic [20:0] o_pc_value, o_push_value;
   logic [7:0] o_wr_data;
   logic o_pc_load, o_push_ret, o_flush, o_busy, o_rd_en, o_wr_en;
   logic [31:0] seed = 32'h00000057;
   logic [11:0] ptr [3] = '{12'h000, 12'h000, 12'h000};
   logic [31:0] r;
   logic [11:0] d;
   int fails = 0;
   int tests_run = 0;

   extension_enable_fuse_exec u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_fuse(i_fuse),
      .i_valid(i_valid), .i_word(i_word), .i_pc(i_pc), .i_tos(i_tos),
      .i_working(i_working), .i_latch_high(i_latch_high),
      .i_latch_upper(i_latch_upper), .i_rd_data(i_rd_data),
      .o_ptr0(o_ptr0), .o_ptr1(o_ptr1), .o_ptr2(o_ptr2),
      .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
      .o_push_ret(o_push_ret), .o_push_value(o_push_value),
      .o_flush(o_flush), .o_busy(o_busy), .o_rd_en(o_rd_en),
      .o_rd_addr(o_rd_addr), .o_wr_en(o_wr_en), .o_wr_addr(o_wr_addr),
      .o_wr_data(o_wr_data));

   always #10 i_clock = ~i_clock;

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function logic inr(input logic [11:0] a);
      return a >= extension_enable_fuse_pkg::IND_BASE && a <= extension_enable_fuse_pkg::IND_LAST;
   endfunction

   task chk(input string name, input logic [31:0] exp,
            input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task chk_ptrs();
      chk("o_ptr0", ptr[0], o_ptr0);
      chk("o_ptr1", ptr[1], o_ptr1);
      chk("o_ptr2", ptr[2], o_ptr2);
   endtask

   // With two set, w2 follows at once so the pair arrives back to back.
   task issue(input logic [15:0] w, input logic two, input logic [15:0] w2);
      @(posedge i_clock);
      r = rnd();
      i_valid <= 1'b1;
      i_word <= w;
      i_pc <= r[20:0];
      i_tos <= r[31:11];
      i_working <= r[7:0];
      i_latch_high <= r[15:8];
      i_latch_upper <= r[23:16];
      i_rd_data <= r[31:24];
      @(posedge i_clock);
      if (two) i_word <= w2;
      else i_valid <= 1'b0;
      #1;
   endtask

   task ptr_op(input logic sub, input logic [1:0] f, input logic [5:0] k);
      issue({7'h74, sub, f, k}, 1'b0, 16'h0000);
      if (f == 2'b11) f = 2'b10;
      ptr[f] = sub ? ptr[f] - 12'(k) : ptr[f] + 12'(k);
   endtask

   task do_move(input logic [6:0] zs, input logic ind, input logic [15:0] w2);
      logic [11:0] src, dst;
      src = ptr[2] + 12'(zs);
      dst = ind ? ptr[2] + 12'(w2[6:0]) : w2[11:0];
      issue({8'hEB, ind, zs}, 1'b1, w2);
      chk("o_rd_en", !inr(src), o_rd_en);
      if (!inr(src)) begin
         chk("o_rd_addr", src, o_rd_addr);
      end
      chk("o_busy", 1'b1, o_busy);
      @(posedge i_clock);
      i_valid <= 1'b0;
      #1;
      chk("o_wr_en", !(ind && inr(dst)), o_wr_en);
      if (!(ind && inr(dst))) begin
         chk("o_wr_addr", dst, o_wr_addr);
         chk("o_wr_data", inr(src) ? 8'h00 : i_rd_data, o_wr_data);
      end
      @(posedge i_clock);
   endtask

   task wrap_up();
      if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // The whole sequence needs a few hundred cycles; this allows far more.
   initial begin
      #400000;
      fails++;
      wrap_up();
   end

   initial begin
      logic [7:0] k;
      repeat (5) @(posedge i_clock);
      i_rst_n <= 1'b1;
      i_fuse <= 1'b1;
      repeat (3) @(posedge i_clock);
      for (int n = 0; n < 12; n++) begin
         r = rnd();
         ptr_op(r[6], 2'(n % 3), (n < 3) ? 6'h3F : r[5:0]);
         chk_ptrs();
         chk("o_pc_load", 1'b0, o_pc_load);
      end
      for (int s = 0; s < 2; s++) begin
         ptr_op(s[0], 2'b11, 6'h3F - 6'(s));
         chk_ptrs();
         chk("o_pc_load", 1'b1, o_pc_load);
         chk("o_pc_value", i_tos, o_pc_value);
         chk("o_flush", 1'b1, o_flush);
         @(posedge i_clock);
         #1;
         chk("o_pc_load", 1'b0, o_pc_load);
      end
      // A push offered during the idle cycle must be ignored.
      issue(16'h0014, 1'b1, 16'hFA5A);
      chk("o_push_ret", 1'b1, o_push_ret);
      chk("o_push_value", 21'(i_pc + 21'h2), o_push_value);
      chk("o_pc_value", {i_latch_upper[4:0], i_latch_high, i_working},
          o_pc_value);
      chk("o_busy", 1'b1, o_busy);
      chk("o_flush", 1'b1, o_flush);
      @(posedge i_clock);
      i_valid <= 1'b0;
      #1;
      chk("o_wr_en", 1'b0, o_wr_en);
      chk("o_pc_load", 1'b0, o_pc_load);
      for (int n = 0; n < 3; n++) begin
         r = rnd();
         k = r[7:0];
         issue({8'hFA, k}, 1'b1, {8'hFA, k ^ 8'hFF});
         chk("o_wr_addr", ptr[2], o_wr_addr);
         chk("o_wr_data", k, o_wr_data);
         ptr[2] = ptr[2] - 12'h001;
         @(posedge i_clock);
         i_valid <= 1'b0;
         #1;
         chk("o_wr_addr", ptr[2], o_wr_addr);
         chk("o_wr_data", k ^ 8'hFF, o_wr_data);
         ptr[2] = ptr[2] - 12'h001;
         chk_ptrs();
      end
      do_move(7'h7F, 1'b0, 16'hF123);
      do_move(7'h05, 1'b1, 16'hFAB6);
      while (ptr[2] !== 12'hFDB) begin
         d = 12'hFDB - ptr[2];
         ptr_op(1'b0, 2'b10, (d > 12'h03F) ? 6'h3F : d[5:0]);
      end
      chk_ptrs();
      do_move(7'h00, 1'b1, 16'hF014);
      do_move(7'h00, 1'b0, 16'hF100);
      do_move(7'h7F, 1'b1, 16'hF025);
      i_fuse <= 1'b0;
      repeat (3) @(posedge i_clock);
      issue(16'hFA77, 1'b0, 16'h0000);
      chk("o_wr_en", 1'b0, o_wr_en);
      chk_ptrs();
      wrap_up();
   end
endmodule
